// [tb.sv]
// Self-checking testbench of the unbalanced load compensation block.
`timescale 1ns/100ps
module tb import ulc_pkg::*; ;
	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] e;
	} ulc_row_t;
	logic               i_clk_sys, i_rst_b, i_run, trig, i_speed_ref_nz, i_bias_select_a, i_bias_select_b;
	ulc_avs_req_t       i_avs;
	logic [N_TERM-1:0]  i_term;
	logic signed [15:0] i_torque_ref, i_host_torque_ref, o_torque_bias, o_torque_cmd;
	logic [31:0]        o_avs_readdata, rd;
	logic               o_avs_waitrequest, o_zero_hold, o_est_active, o_comp_valid, o_drive_on;
	ulc_cfg_t           o_cfg;
	int                 fail_count, check_count, wn;
	logic signed [15:0] sel_exp [4] = '{16'sh0064, 16'shff38, 16'sh0000, 16'sh00c8};
	ulc_row_t           rows [11] = '{'{OFS_EST, 32'h0, 32'h1}, '{OFS_EST, 32'h12c, 32'hc8},
		'{OFS_HOLD, 32'hbb8, 32'h7d0}, '{OFS_GAIN, 32'h4e20b1e0, 32'h2710d8f0},
		'{OFS_PRE12, 32'hf4480bb8, 32'hf83007d0}, '{OFS_PI, 32'h200, 32'h64},
		'{OFS_ASR, 32'h07d07530, 32'h03e84e20}, '{OFS_APR, 32'h00c807d0, 32'h006403e8},
		'{OFS_FILT, 32'h1ff, 32'h64}, '{OFS_CTRL, 32'h3, 32'h3}, '{8'h3c, 32'h5, 32'h0}};
	assign i_term = {2'b00, trig, 1'b0};
	ulc_top #(.P_TICK_CYC(20)) dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_avs(i_avs),
		.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_run(i_run),
		.i_term(i_term), .i_bias_select_a(i_bias_select_a), .i_bias_select_b(i_bias_select_b),
		.i_torque_ref(i_torque_ref), .i_host_torque_ref(i_host_torque_ref),
		.i_speed_ref_nz(i_speed_ref_nz), .o_torque_bias(o_torque_bias), .o_torque_cmd(o_torque_cmd),
		.o_zero_hold(o_zero_hold), .o_est_active(o_est_active), .o_comp_valid(o_comp_valid),
		.o_drive_on(o_drive_on), .o_cfg(o_cfg));
	ulc_host host (.i_clk_sys(i_clk_sys), .o_run(i_run), .o_trig(trig), .o_speed_nz(i_speed_ref_nz));
	initial begin
		i_clk_sys = 1'b0;
		forever #25 i_clk_sys = ~i_clk_sys;
	end
	task end_sim();
		$display("checks %0d failures %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Holds the request until waitrequest is seen low at a rising edge.
	// The slave answers one cycle after it sees the request, so each access spans two edges.
	task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		i_avs <= '{a, ~w, w, d};
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (o_avs_waitrequest !== 1'b0);
		rd = o_avs_readdata;
		i_avs <= '0;
		@(posedge i_clk_sys);
		chk("bus_wait", 32'h2, 32'(n));
	endtask : bus
	// Waits for estimating (0), applied (1) or running (2) to reach a level.
	task wt(input int s, input logic v, input int lim);
		wn = 0;
		while ((s == 0 ? o_est_active : s == 1 ? o_comp_valid : o_drive_on) !== v && wn < lim) begin
			@(posedge i_clk_sys);
			wn++;
		end
		chk("wait_level", 32'h1, 32'(wn < lim));
	endtask : wt
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		fail_count++;
		end_sim();
	end
	initial begin
		{i_rst_b, i_avs, i_bias_select_a, i_bias_select_b, i_torque_ref, i_host_torque_ref} = '0;
		repeat (8) @(posedge i_clk_sys);
		chk("rst_wait", 32'h2, {o_avs_waitrequest, o_drive_on});
		repeat (8) @(posedge i_clk_sys);
		i_rst_b <= 1'b1;
		bus(OFS_HOLD, 1'b0, 32'h0);
		chk("hold_rst", 32'hc8, rd);
		chk("cfg_rst", 32'h1, o_cfg.comp_speed_reg_i);
		foreach (rows[i]) begin
			bus(rows[i].a, 1'b1, rows[i].d);
			bus(rows[i].a, 1'b0, 32'h0);
			chk("reg_rd", rows[i].e, rd);
		end
		$display("test registers done");
		bus(OFS_CTRL, 1'b1, 32'h1);
		bus(OFS_TERM, 1'b1, 32'h4300);
		bus(OFS_EST, 1'b1, 32'h2);
		bus(OFS_PRE12, 1'b1, 32'hff380064);
		bus(OFS_PRE3, 1'b1, 32'hc8);
		i_torque_ref <= 16'sh0123;
		host.run_on();
		repeat (10) @(posedge i_clk_sys);
		chk("est_early", 32'h0, o_est_active);
		for (int k = 0; k < 4; k++) begin
			{i_bias_select_b, i_bias_select_a} <= 2'(k);
			repeat (6) @(posedge i_clk_sys);
			chk("sel_bias", sel_exp[k], o_torque_bias);
		end
		{i_bias_select_b, i_bias_select_a} <= 2'b00;
		host.trig_on();
		wt(0, 1'b1, 6);
		chk("zero_hold", 32'h1, o_zero_hold);
		wt(1, 1'b1, 60);
		chk("est_len", 32'h1, wn >= 38 && wn <= 42);
		repeat (3) @(posedge i_clk_sys);
		chk("bias_latch", 32'h123, o_torque_bias);
		i_torque_ref <= 16'sh0200;
		repeat (4) @(posedge i_clk_sys);
		chk("bias_held", 32'h123, o_torque_bias);
		host.all_off();
		repeat (20) @(posedge i_clk_sys);
		chk("ramp_down", 32'h1, o_torque_bias < 16'sh0123 && o_drive_on);
		wt(2, 1'b0, 3000);
		chk("ramp_len", 32'h1, wn > 400 && wn < 700);
		$display("test speed sequence done");
		bus(OFS_TERM, 1'b1, 32'h0);
		host.run_on();
		wt(0, 1'b1, 10);
		host.nz_on();
		wt(1, 1'b1, 6);
		host.all_off();
		wt(2, 1'b0, 3000);
		$display("test unmapped and early speed done");
		bus(OFS_TERM, 1'b1, 32'h4300);
		host.trig_on();
		repeat (4) @(posedge i_clk_sys);
		host.run_on();
		repeat (100) @(posedge i_clk_sys);
		chk("trig_first", 32'h0, {o_est_active, o_comp_valid});
		host.all_off();
		bus(OFS_CTRL, 1'b1, 32'h0);
		bus(OFS_TERM, 1'b1, 32'h0);
		host.run_on();
		repeat (60) @(posedge i_clk_sys);
		chk("disabled", 32'h0, {o_est_active, o_comp_valid});
		host.all_off();
		wt(2, 1'b0, 100);
		$display("test refusals done");
		bus(OFS_CTRL, 1'b1, 32'h3);
		bus(OFS_HOLD, 1'b1, 32'h4);
		{i_bias_select_b, i_torque_ref, i_host_torque_ref} <= {1'b1, 16'sh0100, 16'sh0010};
		host.run_on();
		wt(1, 1'b1, 100);
		repeat (3) @(posedge i_clk_sys);
		chk("tq_cmd", 32'h110, o_torque_cmd);
		repeat (30) @(posedge i_clk_sys);
		chk("tq_hold", 32'h110, o_torque_cmd);
		repeat (60) @(posedge i_clk_sys);
		chk("tq_ramp", 32'h1, o_torque_cmd < 16'sh0110);
		host.all_off();
		wt(2, 1'b0, 3000);
		$display("test torque control done");
		end_sim();
	end
endmodule : tb

// [ulc_host.sv]
// Elevator host controller model that sequences run, trigger and speed reference.
`timescale 1ns/100ps
module ulc_host (
	// Clock
	input  wire logic i_clk_sys,
	// Host commands
	output logic      o_run,
	output logic      o_trig,
	output logic      o_speed_nz
);
	initial begin
		o_run      = 1'b0;
		o_trig     = 1'b0;
		o_speed_nz = 1'b0;
	end
	// Run comes first unless the bench raises the trigger on purpose beforehand.
	task run_on();
		@(posedge i_clk_sys);
		o_run <= 1'b1;
	endtask : run_on
	task trig_on();
		@(posedge i_clk_sys);
		o_trig <= 1'b1;
	endtask : trig_on
	// The speed reference leaves zero only when the bench commands it.
	task nz_on();
		@(posedge i_clk_sys);
		o_speed_nz <= 1'b1;
	endtask : nz_on
	task all_off();
		@(posedge i_clk_sys);
		o_run      <= 1'b0;
		o_trig     <= 1'b0;
		o_speed_nz <= 1'b0;
	endtask : all_off
endmodule : ulc_host

// [ulc_pkg.sv]
// Constants, register map and carrier types of the unbalanced load compensation block.
package ulc_pkg;
	// Clock rate and the 10 ms timer tick.
	localparam int CLK_HZ   = 32'h01312d00;
	localparam int TICK_MS  = 32'h0000000a;
	localparam int TICK_CYC = CLK_HZ / 32'h000003e8 * TICK_MS;
	// Full rated torque in units of 0.1 percent.
	localparam int FULL_TQ  = 32'h000003e8;
	// Terminal function value that maps a terminal to the estimate trigger.
	localparam logic [7:0] FN_TRIG = 8'h43;
	localparam int N_TERM = 4;
	localparam int TERM_W = 8;

	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_TERM  = 8'h04;
	localparam logic [7:0] OFS_EST   = 8'h08;
	localparam logic [7:0] OFS_HOLD  = 8'h0c;
	localparam logic [7:0] OFS_END   = 8'h10;
	localparam logic [7:0] OFS_GAIN  = 8'h14;
	localparam logic [7:0] OFS_PRE12 = 8'h18;
	localparam logic [7:0] OFS_PRE3  = 8'h1c;
	localparam logic [7:0] OFS_PI    = 8'h20;
	localparam logic [7:0] OFS_ASR   = 8'h24;
	localparam logic [7:0] OFS_APR   = 8'h28;
	localparam logic [7:0] OFS_FILT  = 8'h2c;
	localparam logic [7:0] OFS_STAT  = 8'h30;
	localparam logic [7:0] OFS_BIAS  = 8'h34;
	// Control register bit positions.
	localparam int CTRL_EN = 0;
	localparam int CTRL_TQ = 1;

	// Setting ranges, in the units of each register.
	localparam int EST_MIN  = 32'h00000001;
	localparam int EST_MAX  = 32'h000000c8;
	localparam int HOLD_MIN = 32'h00000001;
	localparam int HOLD_MAX = 32'h000007d0;
	localparam int END_MAX  = 32'h000007d0;
	localparam int GAIN_LIM = 32'h00002710;
	localparam int PRE_LIM  = 32'h000007d0;
	localparam int PI_MAX   = 32'h00000064;
	localparam int ASRP_MAX = 32'h00004e20;
	localparam int ASRI_MIN = 32'h00000001;
	localparam int ASRI_MAX = 32'h000003e8;
	localparam int APRP_MAX = 32'h000003e8;
	localparam int APRD_MAX = 32'h00000064;
	localparam int FILT_MAX = 32'h00000064;

	typedef enum logic [2:0] {S_IDLE, S_WAIT, S_EST, S_APPLY, S_RAMP, S_PLAIN} ulc_state_t;

	typedef struct packed {
		logic [7:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
	} ulc_avs_req_t;

	typedef struct packed {
		logic               en;
		logic               tq;
		logic [31:0]        termfn;
		logic [15:0]        est;
		logic [15:0]        hold;
		logic [15:0]        endt;
		logic signed [15:0] pre1;
		logic signed [15:0] pre2;
		logic signed [15:0] pre3;
	} ulc_ctl_t;

	typedef struct packed {
		logic [15:0]        comp_speed_reg_p;
		logic [15:0]        comp_speed_reg_i;
		logic [15:0]        comp_position_reg_p;
		logic [15:0]        comp_position_reg_d;
		logic [15:0]        comp_speed_filter_const;
		logic [15:0]        pi_bias_integral_const;
		logic signed [15:0] driving_bias_gain;
		logic signed [15:0] braking_bias_gain;
	} ulc_cfg_t;

	// Values after reset.
	localparam ulc_ctl_t CTL_RST = '{est: 16'h0064, hold: 16'h00c8, endt: 16'h0064, default: '0};
	localparam ulc_cfg_t CFG_RST = '{comp_speed_reg_i: 16'h0001, default: '0};
endpackage : ulc_pkg

// [ulc_ramp.sv]
// Holds a signed torque value and ramps it to zero at the end-time rate.
`timescale 1ns/100ps
module ulc_ramp import ulc_pkg::*; #(
	parameter int P_TICK_CYC = TICK_CYC
) (
	// Clock and reset
	input  wire logic               i_clk_sys,
	input  wire logic               i_rst_b,
	// Control
	input  wire logic               i_load,
	input  wire logic signed [15:0] i_load_val,
	input  wire logic               i_go,
	input  wire logic [15:0]        i_end_time,
	// Held value
	output logic signed [15:0]      o_value
);
	logic [31:0]        acc;
	logic [31:0]        next_acc;
	logic signed [15:0] next_value;
	logic [31:0]        thr;

	// One unit of 0.1 percent is removed each time the accumulator passes the threshold,
	// so full torque takes exactly end_time ticks.
	always_comb begin
		thr        = 32'(i_end_time) * 32'(P_TICK_CYC);
		next_acc   = acc;
		next_value = o_value;
		if (i_load) begin
			next_value = i_load_val;
			next_acc   = '0;
		end else if (i_go && o_value != 16'sh0000) begin
			if (i_end_time == 16'h0000) begin
				next_value = 16'sh0000;
			end else if (acc + 32'(FULL_TQ) >= thr) begin
				next_acc   = acc + 32'(FULL_TQ) - thr;
				next_value = (o_value > 16'sh0000) ? o_value - 16'sh0001 : o_value + 16'sh0001;
			end else begin
				next_acc = acc + 32'(FULL_TQ);
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			acc     <= '0;
			o_value <= '0;
		end else begin
			acc     <= next_acc;
			o_value <= next_value;
		end
	end
endmodule : ulc_ramp

// [ulc_tick.sv]
// Free-running 10 ms tick generator with a phase restart.
`timescale 1ns/100ps
module ulc_tick import ulc_pkg::*; #(
	parameter int P_TICK_CYC = TICK_CYC
) (
	// Clock and reset
	input  wire logic i_clk_sys,
	input  wire logic i_rst_b,
	// Control and tick
	input  wire logic i_clear,
	output logic      o_tick
);
	logic [31:0] cnt;
	logic [31:0] next_cnt;
	logic        next_tick;

	always_comb begin
		next_cnt  = cnt + 32'h1;
		next_tick = 1'b0;
		if (i_clear) begin
			next_cnt = '0;
		end else if (cnt >= 32'(P_TICK_CYC - 1)) begin
			next_cnt  = '0;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt    <= '0;
			o_tick <= 1'b0;
		end else begin
			cnt    <= next_cnt;
			o_tick <= next_tick;
		end
	end
endmodule : ulc_tick

// [ulc_top.sv]
// Unbalanced load compensation sequencer with its settings behind an Avalon-MM slave.
`timescale 1ns/100ps
module ulc_top import ulc_pkg::*; #(
	parameter int P_TICK_CYC = TICK_CYC
) (
	// Clock and reset
	input  wire logic               i_clk_sys,
	input  wire logic               i_rst_b,
	// Register bus
	input  wire ulc_avs_req_t       i_avs,
	output logic [31:0]             o_avs_readdata,
	output logic                    o_avs_waitrequest,
	// Host pins
	input  wire logic               i_run,
	input  wire logic [N_TERM-1:0]  i_term,
	input  wire logic               i_bias_select_a,
	input  wire logic               i_bias_select_b,
	// Drive signals on the same clock
	input  wire logic signed [15:0] i_torque_ref,
	input  wire logic signed [15:0] i_host_torque_ref,
	input  wire logic               i_speed_ref_nz,
	// Drive outputs
	output logic signed [15:0]      o_torque_bias,
	output logic signed [15:0]      o_torque_cmd,
	output logic                    o_zero_hold,
	output logic                    o_est_active,
	output logic                    o_comp_valid,
	output logic                    o_drive_on,
	output ulc_cfg_t                o_cfg
);
	function automatic logic [15:0] clampw(input logic [15:0] w, input int lo, input int hi);
		int v;
		v = int'($signed(w));
		if (v < lo) begin
			v = lo;
		end else if (v > hi) begin
			v = hi;
		end
		return v[15:0];
	endfunction : clampw

	function automatic logic signed [15:0] sat16(input logic signed [16:0] v);
		if (v[16] != v[15]) begin
			return v[16] ? 16'sh8000 : 16'sh7fff;
		end
		return v[15:0];
	endfunction : sat16

	// Pin synchronisers: run, terminals, select a, select b.
	localparam int NPIN = N_TERM + 3;
	logic [NPIN-1:0] pin_m;
	logic [NPIN-1:0] pin_s;
	logic            run_s;
	logic [N_TERM-1:0] term_s;
	logic [1:0]      sel_s;

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pin_m <= '0;
			pin_s <= '0;
		end else begin
			pin_m <= {i_bias_select_b, i_bias_select_a, i_term, i_run};
			pin_s <= pin_m;
		end
	end
	assign run_s  = pin_s[0];
	assign term_s = pin_s[N_TERM:1];
	assign sel_s  = pin_s[NPIN-1:N_TERM+1];

	// Settings registers and the bus slave.
	ulc_ctl_t           ctl;
	ulc_ctl_t           next_ctl;
	ulc_cfg_t           next_cfg;
	logic [31:0]        next_readdata;
	logic               next_wait;
	logic [31:0]        rdata;
	logic [31:0]        wd;
	logic               wr_take;
	ulc_state_t         state;
	logic signed [15:0] comp;
	logic               mapped;

	assign wd      = i_avs.writedata;
	assign wr_take = i_avs.write && !o_avs_waitrequest;

	always_comb begin
		unique case (i_avs.address)
			OFS_CTRL:  rdata = {30'h0, ctl.tq, ctl.en};
			OFS_TERM:  rdata = ctl.termfn;
			OFS_EST:   rdata = {16'h0, ctl.est};
			OFS_HOLD:  rdata = {16'h0, ctl.hold};
			OFS_END:   rdata = {16'h0, ctl.endt};
			OFS_GAIN:  rdata = {o_cfg.braking_bias_gain, o_cfg.driving_bias_gain};
			OFS_PRE12: rdata = {ctl.pre2, ctl.pre1};
			OFS_PRE3:  rdata = {16'h0, ctl.pre3};
			OFS_PI:    rdata = {16'h0, o_cfg.pi_bias_integral_const};
			OFS_ASR:   rdata = {o_cfg.comp_speed_reg_i, o_cfg.comp_speed_reg_p};
			OFS_APR:   rdata = {o_cfg.comp_position_reg_d, o_cfg.comp_position_reg_p};
			OFS_FILT:  rdata = {16'h0, o_cfg.comp_speed_filter_const};
			OFS_STAT:  rdata = {comp, 11'h0, mapped, run_s, state};
			OFS_BIAS:  rdata = {o_torque_cmd, o_torque_bias};
			default:   rdata = 32'h0;
		endcase
	end

	// Every access takes two cycles: the slave drops waitrequest in the cycle after the request.
	always_comb begin
		next_ctl      = ctl;
		next_cfg      = o_cfg;
		next_wait     = 1'b1;
		next_readdata = o_avs_readdata;
		if ((i_avs.read || i_avs.write) && o_avs_waitrequest) begin
			next_wait     = 1'b0;
			next_readdata = i_avs.read ? rdata : 32'h0;
		end
		if (wr_take) begin
			case (i_avs.address)
				OFS_CTRL: begin
					next_ctl.en = wd[CTRL_EN];
					next_ctl.tq = wd[CTRL_TQ];
				end
				OFS_TERM:  next_ctl.termfn = wd;
				OFS_EST:   next_ctl.est = clampw(wd[15:0], EST_MIN, EST_MAX);
				OFS_HOLD:  next_ctl.hold = clampw(wd[15:0], HOLD_MIN, HOLD_MAX);
				OFS_END:   next_ctl.endt = clampw(wd[15:0], 0, END_MAX);
				OFS_GAIN: begin
					next_cfg.driving_bias_gain = clampw(wd[15:0], -GAIN_LIM, GAIN_LIM);
					next_cfg.braking_bias_gain = clampw(wd[31:16], -GAIN_LIM, GAIN_LIM);
				end
				OFS_PRE12: begin
					next_ctl.pre1 = clampw(wd[15:0], -PRE_LIM, PRE_LIM);
					next_ctl.pre2 = clampw(wd[31:16], -PRE_LIM, PRE_LIM);
				end
				OFS_PRE3:  next_ctl.pre3 = clampw(wd[15:0], -PRE_LIM, PRE_LIM);
				OFS_PI:    next_cfg.pi_bias_integral_const = clampw(wd[15:0], 0, PI_MAX);
				OFS_ASR: begin
					next_cfg.comp_speed_reg_p = clampw(wd[15:0], 0, ASRP_MAX);
					next_cfg.comp_speed_reg_i = clampw(wd[31:16], ASRI_MIN, ASRI_MAX);
				end
				OFS_APR: begin
					next_cfg.comp_position_reg_p = clampw(wd[15:0], 0, APRP_MAX);
					next_cfg.comp_position_reg_d = clampw(wd[31:16], 0, APRD_MAX);
				end
				OFS_FILT:  next_cfg.comp_speed_filter_const = clampw(wd[15:0], 0, FILT_MAX);
				default:   next_ctl = ctl;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctl               <= CTL_RST;
			o_cfg             <= CFG_RST;
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata    <= '0;
		end else begin
			ctl               <= next_ctl;
			o_cfg             <= next_cfg;
			o_avs_waitrequest <= next_wait;
			o_avs_readdata    <= next_readdata;
		end
	end

	// Trigger mapping and host bias selection.
	logic               trig_s;
	logic signed [15:0] host_bias;
	logic signed [15:0] next_host_bias;
	logic [15:0]        hold_eff;

	always_comb begin
		mapped = 1'b0;
		trig_s = 1'b0;
		for (int k = 0; k < N_TERM; k++) begin
			if (ctl.termfn[k*TERM_W +: TERM_W] == FN_TRIG) begin
				mapped = 1'b1;
				trig_s = trig_s | term_s[k];
			end
		end
		unique case (sel_s)
			2'b00:   next_host_bias = ctl.pre1;
			2'b01:   next_host_bias = ctl.pre2;
			2'b10:   next_host_bias = 16'sh0000;
			2'b11:   next_host_bias = ctl.pre3;
		endcase
		hold_eff = (ctl.est > ctl.hold) ? ctl.est : ctl.hold;
	end

	// Sequencer.
	ulc_state_t         next_state;
	logic [15:0]        tcnt;
	logic [15:0]        next_tcnt;
	logic [15:0]        tnext;
	logic signed [15:0] next_comp;
	logic signed [15:0] cval;
	logic signed [15:0] ramp_val;
	logic signed [15:0] ld_val;
	logic               ld;
	logic               go;
	logic               tclr;
	logic               tick;
	logic               in_comp;

	ulc_tick #(.P_TICK_CYC(P_TICK_CYC)) u_tick (
		.i_clk_sys (i_clk_sys),
		.i_rst_b   (i_rst_b),
		.i_clear   (tclr),
		.o_tick    (tick)
	);

	ulc_ramp #(.P_TICK_CYC(P_TICK_CYC)) u_ramp (
		.i_clk_sys  (i_clk_sys),
		.i_rst_b    (i_rst_b),
		.i_load     (ld),
		.i_load_val (ld_val),
		.i_go       (go),
		.i_end_time (ctl.endt),
		.o_value    (ramp_val)
	);

	always_comb begin
		next_state = state;
		next_comp  = comp;
		tnext      = tick ? tcnt + 16'h0001 : tcnt;
		next_tcnt  = tcnt;
		cval       = sat16(17'(i_torque_ref) - 17'(host_bias));
		ld         = 1'b0;
		ld_val     = 16'sh0000;
		go         = 1'b0;
		tclr       = 1'b0;
		unique case (state)
			S_IDLE: begin
				ld        = 1'b1;
				next_comp = 16'sh0000;
				if (run_s) begin
					if (!ctl.en) begin
						next_state = S_PLAIN;
					end else if (mapped) begin
						next_state = trig_s ? S_PLAIN : S_WAIT;
					end else begin
						next_state = S_EST;
						next_tcnt  = 16'h0000;
						tclr       = 1'b1;
					end
				end
			end
			S_WAIT: begin
				if (!run_s) begin
					next_state = S_IDLE;
				end else if (trig_s) begin
					next_state = S_EST;
					next_tcnt  = 16'h0000;
					tclr       = 1'b1;
				end
			end
			S_EST: begin
				next_tcnt = tnext;
				if (!run_s) begin
					next_state = S_IDLE;
				end else if (tnext >= ctl.est || (!ctl.tq && i_speed_ref_nz)) begin
					next_state = S_APPLY;
					next_comp  = cval;
					ld         = 1'b1;
					ld_val     = ctl.tq ? cval : sat16(17'(host_bias) + 17'(cval));
				end
			end
			S_APPLY: begin
				next_tcnt = (tcnt >= hold_eff) ? tcnt : tnext;
				if (ctl.tq) begin
					if (!run_s) begin
						next_state = S_IDLE;
					end else if (tcnt >= hold_eff) begin
						next_state = S_RAMP;
					end
				end else if (!run_s) begin
					next_state = S_RAMP;
				end
			end
			S_RAMP: begin
				go = 1'b1;
				if (ctl.tq ? !run_s : (ramp_val == 16'sh0000)) begin
					next_state = S_IDLE;
				end
			end
			S_PLAIN: begin
				if (!run_s) begin
					next_state = S_IDLE;
				end
			end
		endcase
	end

	assign in_comp = (state == S_APPLY) || (state == S_RAMP);

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state         <= S_IDLE;
			tcnt          <= '0;
			comp          <= '0;
			host_bias     <= '0;
			o_torque_bias <= '0;
			o_torque_cmd  <= '0;
			o_zero_hold   <= 1'b0;
			o_est_active  <= 1'b0;
			o_comp_valid  <= 1'b0;
			o_drive_on    <= 1'b0;
		end else begin
			state         <= next_state;
			tcnt          <= next_tcnt;
			comp          <= next_comp;
			host_bias     <= next_host_bias;
			o_torque_bias <= (!ctl.tq && in_comp) ? ramp_val : host_bias;
			o_torque_cmd  <= sat16(17'(i_host_torque_ref) + 17'((ctl.tq && in_comp) ? ramp_val : 16'sh0000));
			o_zero_hold   <= (next_state == S_EST) && !ctl.tq;
			o_est_active  <= (next_state == S_EST);
			o_comp_valid  <= (next_state == S_APPLY) || (next_state == S_RAMP);
			o_drive_on    <= (next_state != S_IDLE);
		end
	end

	// Checks.
	default clocking dc @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);

	comp_off_a: assert property ((state == S_IDLE && run_s && !ctl.en) |=> state == S_PLAIN)
		else $error("run with compensation off did not stay plain");
	trig_start_a: assert property ((state == S_WAIT && run_s && trig_s) |=> state == S_EST && o_est_active)
		else $error("trigger after run did not start estimation");
	run_start_a: assert property ((state == S_IDLE && run_s && ctl.en && !mapped) |=> state == S_EST)
		else $error("run without mapped trigger did not start estimation");
	trig_first_a: assert property ((state == S_IDLE && run_s && ctl.en && mapped && trig_s) |=> state == S_PLAIN)
		else $error("trigger before run still led to compensation");
	speed_nz_a: assert property ((state == S_EST && run_s && !ctl.tq && i_speed_ref_nz) |=> state == S_APPLY)
		else $error("nonzero speed reference did not end estimation");
	zero_hold_a: assert property ((state == S_EST && !ctl.tq) |-> o_zero_hold)
		else $error("zero hold not active while estimating in speed control");
	bias_latch_a: assert property ((state == S_EST && next_state == S_APPLY && !ctl.tq
		&& i_torque_ref < 16'sh7000 && i_torque_ref > -16'sh7000) |-> ##2 o_torque_bias == $past(i_torque_ref, 2))
		else $error("latched bias differs from internal torque reference");
	host_only_a: assert property ((state == S_WAIT && !ctl.tq) |=> o_torque_bias == $past(host_bias))
		else $error("bias before the trigger is not the host bias");
	shut_end_a: assert property ((state == S_RAMP && !ctl.tq && ramp_val == 16'sh0000) |=> !o_drive_on)
		else $error("shutdown did not follow the end of the ramp");
	tq_add_a: assert property ((state == S_APPLY && ctl.tq)
		|=> o_torque_cmd == sat16(17'($past(i_host_torque_ref)) + 17'($past(ramp_val))))
		else $error("torque command lacks the compensation");
	hold_eff_a: assert property ((state == S_APPLY && ctl.tq && run_s && tcnt >= hold_eff)
		|=> state == S_RAMP && tcnt >= $past(ctl.est))
		else $error("ramp did not start after the effective holding time");
	est_range_a: assert property (ctl.est >= 16'(EST_MIN) && ctl.est <= 16'(EST_MAX)
		&& ctl.hold >= 16'(HOLD_MIN) && ctl.hold <= 16'(HOLD_MAX))
		else $error("time setting out of range");
	sel_zero_a: assert property ((sel_s == 2'b10) |=> host_bias == 16'sh0000)
		else $error("select b alone did not give zero bias");

	est_done_c: cover property (state == S_EST ##1 state == S_APPLY);
	shut_ramp_c: cover property (state == S_RAMP && !ctl.tq ##1 state == S_IDLE);
	tq_ramp_c: cover property (state == S_APPLY && ctl.tq ##1 state == S_RAMP);
	bus_write_c: cover property (wr_take && i_avs.address == OFS_EST);
endmodule : ulc_top
